// File: rtl/rwg_params.svh
// constants for the reset and watchdog generator
`ifndef RWG_PARAMS_SVH
`define RWG_PARAMS_SVH
// register byte addresses
`define RWG_ADDR_MODE 12'h000
`define RWG_ADDR_BLOCK_SOFT_RESET_REG 12'h004
`define RWG_ADDR_USB 12'h008
`define RWG_ADDR_SYS 12'h00c
`define RWG_ADDR_WDOG 12'h010
`define RWG_ADDR_STAT 12'h014
// mode register fields and reset value
`define RWG_MODE_RESET 8'h00
`define RWG_RSS_LO_BIT 0
`define RWG_RSS_HI_BIT 1
// block soft reset bits
`define RWG_BLOCK_SOFT_RESET_REG_TR_BIT 0
`define RWG_BLOCK_SOFT_RESET_REG_RSTO_BIT 1
`define RWG_BLOCK_SOFT_RESET_REG_HDLC_BIT 2
// usb control bits
`define RWG_USB_SWR_BIT 0
`define RWG_USB_ENDPOINT_INIT_FLAG_BIT 1
// system control bits
`define RWG_SYS_CPU_BIT 0
// watchdog restart bits
`define RWG_WD_A_BIT 0
`define RWG_WD_B_BIT 1
// status bits
`define RWG_STAT_WOV_BIT 0
`define RWG_STAT_LD_BIT 1
// timing figures
`define RWG_CLK_MHZ 100
`define RWG_POR_INIT_CLKS 12
`define RWG_DCL_PER_NS 652
`define RWG_L1_MIN_CLKS ((2 * `RWG_DCL_PER_NS + 9) / 10)
`define RWG_USB_RST_CLKS 16
`define RWG_PULSE_FRAMES 2
`define RWG_WD_MS 128
`define RWG_WD_FRAMES (`RWG_WD_MS * 8)
`define RWG_WD_DELAY_FRAMES 8
`define RWG_WD_PULSE_FRAMES 1
`endif

// File: rtl/rwg_pkg.sv
// types for the reset and watchdog generator
package rwg_pkg;
    typedef enum logic [1:0] {
        RWG_SRC_NONE,
        RWG_SRC_STROBE,
        RWG_SRC_CI_AWAKE,
        RWG_SRC_WDOG
    } rwg_src_e;
    typedef enum logic [1:0] {
        RWG_WR_IDLE,
        RWG_WR_ARMED
    } rwg_wdseq_e;
    typedef logic [31:0] rwg_word_t;
endpackage

// File: rtl/rwg_top.sv
// reset and watchdog generator with apb register access
// Summary of operation
// - twelve clock init after reset release
// - hardware reset reaches output when enabled
// - hardware reset leaves usb function alone
// - software sets usb reset, hardware clears
// - usb reset clear sets endpoint init flag
// - usb bus reset resets usb function
// - layer-1 and hdlc block soft resets never drive reset pin
// - cpu reset bit for download switch
// - source select picks output reset sources
// - select 01 gives strobe, no reset
// - soft reset-out bit always drives pin
// - selecting watchdog clears and starts timer
// - watchdog select locked until hardware reset
// - expiry sets flag, 125 us pulse
// - watchdog halts while clocks suspended
// - block reset bits clear themselves
// - layer-1 forced to reset idle state
// - layer-1 reset at least two data clocks
// - c/i change gives 125-250 us pulse
// - awake low restarts oscillator, gives pulse
// - pulses timed on 8 kHz frame sync
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "rwg_params.svh"
module rwg_top #(
    parameter int WD_FRAMES = `RWG_WD_FRAMES,
    parameter int CI_WIDTH = 4
) (
    input wire logic CLK_IN, // system clock
    input wire logic RST_N_IN, // external hardware reset, sync low
    input wire logic PSEL_IN, // apb select
    input wire logic PENABLE_IN, // apb access phase
    input wire logic PWRITE_IN, // apb direction
    input wire logic [11:0] PADDR_IN, // apb byte address
    input wire logic [31:0] PWDATA_IN, // apb write data
    output rwg_pkg::rwg_word_t PRDATA_OUT, // apb read data
    output logic PREADY_OUT, // apb ready
    output logic PSLVERR_OUT, // apb error
    input wire logic FSC_TICK_IN, // one-cycle pulse per 8 kHz frame
    input wire logic [CI_WIDTH-1:0] CI_DOWN_IN, // downstream c/i code
    input wire logic SUB_AWAKE_N_IN, // subscriber awake, active low
    input wire logic USB_BUS_RESET_IN, // bus reset signalling seen
    input wire logic USB_RST_DONE_IN, // usb reset operation finished
    input wire logic CLK_RUN_IN, // low while suspend stops clocks
    input wire logic STROBE_IN, // serial data strobe to mux out
    output logic RESET_OUT_STROBE_N_OUT, // multiplexed reset/strobe pin
    output logic CHIP_INIT_OUT, // high during post-reset init cycle
    output logic USB_RESET_OUT, // usb function reset
    output logic CPU_RESET_OUT, // processor reset
    output logic L1_RESET_OUT, // layer-1 reset, forces idle
    output logic HDLC_RESET_OUT, // hdlc block reset
    output logic OSC_WAKE_OUT, // oscillator restart request
    output logic WD_RESET_OUT // watchdog reset with hardware effect
);
    import rwg_pkg::*;

    initial begin
        // start-of-simulation check of parameters
        if (WD_FRAMES < 2 || WD_FRAMES > 65535 || CI_WIDTH < 1) begin
            $error("rwg_top: unsupported parameter values");
        end
    end

    localparam int L1_MIN = `RWG_L1_MIN_CLKS; // two data clock periods in cycles

    // whole state of the block
    typedef struct packed {
        logic [3:0] init_cnt; // post-reset init counter
        logic [7:0] mode; // mode register
        logic wd_lock; // watchdog mode locked
        logic usb_swr; // usb soft reset bit
        logic endpoint_init_flag; // endpoint init flag
        logic [4:0] usb_cnt; // usb reset length
        logic cpu_rst; // processor reset bit
        logic rsto_req; // soft reset-out request
        logic hdlc_req; // hdlc reset request
        logic [7:0] l1_cnt; // layer-1 reset length
        logic [1:0] sw_fr; // soft reset-out frame count
        logic [1:0] src_fr; // internal source frame count
        logic src_act; // internal source pulse running
        logic [CI_WIDTH-1:0] ci_prev; // last c/i code
        logic awake_prev; // last awake level
        rwg_wdseq_e wd_seq; // restart sequence state
        logic [15:0] wd_cnt; // watchdog frame count
        logic wd_exp; // expired, waiting for pulse
        logic [3:0] wd_dly; // delay before pulse
        logic [1:0] wd_fr; // watchdog pulse frames
        logic wd_act; // watchdog pulse running
        logic wd_overflow_flag; // overflow flag
        logic ld; // level detect flag
        logic [31:0] rdata; // read data
    } rwg_state_s;

    rwg_state_s s_q, s_d;
    logic wr_en, rd_en, hit, ci_chg, awake_fall, tick, wd_start;
    rwg_src_e src;

    // bus decode, zero wait states
    always_comb begin
        wr_en = PSEL_IN & PENABLE_IN & PWRITE_IN;
        rd_en = PSEL_IN & ~PENABLE_IN & ~PWRITE_IN;
        hit = (PADDR_IN == `RWG_ADDR_MODE) || (PADDR_IN == `RWG_ADDR_BLOCK_SOFT_RESET_REG) ||
              (PADDR_IN == `RWG_ADDR_USB) || (PADDR_IN == `RWG_ADDR_SYS) ||
              (PADDR_IN == `RWG_ADDR_WDOG) || (PADDR_IN == `RWG_ADDR_STAT);
        src = rwg_src_e'(s_q.mode[1:0]);
        ci_chg = (CI_DOWN_IN != s_q.ci_prev);
        awake_fall = s_q.awake_prev & ~SUB_AWAKE_N_IN;
        tick = FSC_TICK_IN & CLK_RUN_IN;
    end

    // next state
    always_comb begin
        s_d = s_q;
        wd_start = 1'b0;
        s_d.ci_prev = CI_DOWN_IN;
        s_d.awake_prev = SUB_AWAKE_N_IN;
        // init cycle after reset release
        if (s_q.init_cnt != 4'h0) begin
            s_d.init_cnt = s_q.init_cnt - 4'h1;
        end
        // self-clearing block resets
        if (s_q.l1_cnt != 8'h00) begin
            s_d.l1_cnt = s_q.l1_cnt - 8'h01;
        end
        s_d.hdlc_req = 1'b0;
        // usb reset runs until done, then flags endpoints
        if (s_q.usb_swr) begin
            if (s_q.usb_cnt != 5'h00) begin
                s_d.usb_cnt = s_q.usb_cnt - 5'h01;
            end else if (USB_RST_DONE_IN) begin
                s_d.usb_swr = 1'b0;
                s_d.endpoint_init_flag = 1'b1;
            end
        end
        // soft reset-out pulse timed on frames
        if (s_q.rsto_req && tick) begin
            // ends on the second frame tick: one to two frames long
            if (s_q.sw_fr == 2'(`RWG_PULSE_FRAMES - 1)) begin
                s_d.rsto_req = 1'b0;
                s_d.sw_fr = 2'h0;
            end else begin
                s_d.sw_fr = s_q.sw_fr + 2'h1;
            end
        end
        // c/i change and awake sources
        // mode falls back only once the pulse is over, so the pin can show it
        if ((ci_chg || awake_fall) && src == RWG_SRC_CI_AWAKE) begin
            s_d.src_act = 1'b1;
            s_d.src_fr = 2'h0;
        end else if ((ci_chg || awake_fall) && src == RWG_SRC_STROBE) begin
            s_d.mode = `RWG_MODE_RESET;
        end else if (s_q.src_act && tick) begin
            // ends on the second frame tick: 125 to 250 us
            if (s_q.src_fr == 2'(`RWG_PULSE_FRAMES - 1)) begin
                s_d.src_act = 1'b0;
                if (!s_q.wd_lock) begin
                    s_d.mode = `RWG_MODE_RESET;
                end
            end else begin
                s_d.src_fr = s_q.src_fr + 2'h1;
            end
        end
        if (awake_fall) begin
            s_d.ld = 1'b1;
        end
        // watchdog timer
        if (s_q.wd_lock && !s_q.wd_exp && tick) begin
            if (s_q.wd_cnt == 16'(WD_FRAMES - 1)) begin
                s_d.wd_exp = 1'b1;
                s_d.wd_overflow_flag = 1'b1;
                s_d.wd_dly = 4'h0;
                s_d.wd_cnt = 16'h0000;
            end else begin
                s_d.wd_cnt = s_q.wd_cnt + 16'h0001;
            end
        end
        if (s_q.wd_exp && tick) begin
            if (s_q.wd_dly == 4'(`RWG_WD_DELAY_FRAMES - 1)) begin
                s_d.wd_exp = 1'b0;
                s_d.wd_act = 1'b1;
                s_d.wd_fr = 2'h0;
            end else begin
                s_d.wd_dly = s_q.wd_dly + 4'h1;
            end
        end
        if (s_q.wd_act && tick) begin
            // expiry pulse lasts one frame
            if (s_q.wd_fr == 2'(`RWG_WD_PULSE_FRAMES - 1)) begin
                s_d.wd_act = 1'b0;
            end else begin
                s_d.wd_fr = s_q.wd_fr + 2'h1;
            end
        end
        // bus reset from upstream
        if (USB_BUS_RESET_IN) begin
            s_d.usb_swr = 1'b1;
            s_d.usb_cnt = 5'(`RWG_USB_RST_CLKS);
        end
        // register writes
        s_d.rdata = 32'h0000_0000;
        if (wr_en) begin
            unique case (PADDR_IN)
                `RWG_ADDR_MODE: begin
                    if (!s_q.wd_lock) begin
                        s_d.mode = PWDATA_IN[7:0];
                        if (PWDATA_IN[1:0] == 2'b11) begin
                            s_d.wd_lock = 1'b1;
                            wd_start = 1'b1;
                        end
                    end else begin
                        s_d.mode[7:2] = PWDATA_IN[7:2];
                    end
                end
                `RWG_ADDR_BLOCK_SOFT_RESET_REG: begin
                    if (PWDATA_IN[`RWG_BLOCK_SOFT_RESET_REG_TR_BIT]) begin
                        s_d.l1_cnt = 8'(L1_MIN);
                    end
                    if (PWDATA_IN[`RWG_BLOCK_SOFT_RESET_REG_RSTO_BIT]) begin
                        s_d.rsto_req = 1'b1;
                        s_d.sw_fr = 2'h0;
                    end
                    s_d.hdlc_req = PWDATA_IN[`RWG_BLOCK_SOFT_RESET_REG_HDLC_BIT];
                end
                `RWG_ADDR_USB: begin
                    if (PWDATA_IN[`RWG_USB_SWR_BIT]) begin
                        s_d.usb_swr = 1'b1;
                        s_d.usb_cnt = 5'(`RWG_USB_RST_CLKS);
                    end
                    if (PWDATA_IN[`RWG_USB_ENDPOINT_INIT_FLAG_BIT] && !s_d.endpoint_init_flag) begin
                        s_d.endpoint_init_flag = s_d.endpoint_init_flag;
                    end else if (PWDATA_IN[`RWG_USB_ENDPOINT_INIT_FLAG_BIT]) begin
                        s_d.endpoint_init_flag = (s_q.usb_swr && !s_d.usb_swr); // set wins
                    end
                end
                `RWG_ADDR_SYS: begin
                    s_d.cpu_rst = PWDATA_IN[`RWG_SYS_CPU_BIT];
                end
                `RWG_ADDR_WDOG: begin
                    // two-step restart, wrong order disarms
                    if (PWDATA_IN[1:0] == 2'b01) begin
                        s_d.wd_seq = RWG_WR_ARMED;
                    end else if (PWDATA_IN[1:0] == 2'b10 && s_q.wd_seq == RWG_WR_ARMED) begin
                        s_d.wd_seq = RWG_WR_IDLE;
                        wd_start = 1'b1;
                    end else begin
                        s_d.wd_seq = RWG_WR_IDLE;
                    end
                end
                `RWG_ADDR_STAT: begin
                    // write one to clear, new event wins, except an expiry while the overflow flag is already set
                    if (PWDATA_IN[`RWG_STAT_WOV_BIT] && !(s_d.wd_overflow_flag && !s_q.wd_overflow_flag)) begin
                        s_d.wd_overflow_flag = 1'b0;
                    end
                    if (PWDATA_IN[`RWG_STAT_LD_BIT] && !awake_fall) begin
                        s_d.ld = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        if (wd_start && !s_q.wd_act) begin
            s_d.wd_cnt = 16'h0000;
            s_d.wd_exp = 1'b0;
        end
        // read mux
        if (rd_en) begin
            unique case (PADDR_IN)
                `RWG_ADDR_MODE: s_d.rdata = {24'h0, s_q.mode};
                `RWG_ADDR_USB: s_d.rdata = {30'h0, s_q.endpoint_init_flag, s_q.usb_swr};
                `RWG_ADDR_SYS: s_d.rdata = {31'h0, s_q.cpu_rst};
                `RWG_ADDR_WDOG: s_d.rdata = {16'h0, s_q.wd_cnt};
                `RWG_ADDR_STAT: s_d.rdata = {30'h0, s_q.ld, s_q.wd_overflow_flag};
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end else begin
            s_d.rdata = s_q.rdata;
        end
    end

    // state register with synchronous reset
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            s_q <= '0;
            s_q.init_cnt <= 4'(`RWG_POR_INIT_CLKS);
            s_q.l1_cnt <= 8'(L1_MIN);
            s_q.awake_prev <= 1'b1;
            s_q.usb_swr <= 1'b0;
        end else if (s_q.init_cnt != 4'h0) begin
            s_q.init_cnt <= s_d.init_cnt;
            s_q.ci_prev <= s_d.ci_prev;
            s_q.awake_prev <= s_d.awake_prev;
            s_q.l1_cnt <= s_d.l1_cnt;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs
    always_comb begin
        PRDATA_OUT = s_q.rdata;
        PREADY_OUT = 1'b1;
        PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~hit;
        CHIP_INIT_OUT = (s_q.init_cnt != 4'h0);
        USB_RESET_OUT = s_q.usb_swr;
        CPU_RESET_OUT = s_q.cpu_rst | CHIP_INIT_OUT;
        L1_RESET_OUT = (s_q.l1_cnt != 8'h00) | ~RST_N_IN | s_q.wd_act;
        HDLC_RESET_OUT = s_q.hdlc_req;
        OSC_WAKE_OUT = ~SUB_AWAKE_N_IN;
        WD_RESET_OUT = s_q.wd_act;
        // pin: soft bit always, else selected source, strobe mode
        // a running c/i or awake pulse keeps the select at 10 until it ends
        if (s_q.rsto_req) begin
            RESET_OUT_STROBE_N_OUT = 1'b0;
        end else if (src == RWG_SRC_STROBE) begin
            RESET_OUT_STROBE_N_OUT = STROBE_IN;
        end else if (src == RWG_SRC_CI_AWAKE) begin
            RESET_OUT_STROBE_N_OUT = ~(s_q.src_act | ~RST_N_IN);
        end else if (src == RWG_SRC_WDOG) begin
            RESET_OUT_STROBE_N_OUT = ~(s_q.wd_act | ~RST_N_IN);
        end else begin
            RESET_OUT_STROBE_N_OUT = 1'b1;
        end
    end

    // assertions
    a_wd_lock_kept: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        s_q.wd_lock |=> s_q.wd_lock && s_q.mode[1:0] == 2'b11)
        else $error("watchdog select changed after lock");
    a_endpoint_init_flag_on_clear: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        $fell(s_q.usb_swr) |-> s_q.endpoint_init_flag)
        else $error("endpoint flag not set on usb reset clear");
    a_soft_pin_low: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        s_q.rsto_req |-> !RESET_OUT_STROBE_N_OUT)
        else $error("soft reset-out not on pin");
    a_none_pin_high: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        (s_q.mode[1:0] == 2'b00 && !s_q.rsto_req) |-> RESET_OUT_STROBE_N_OUT)
        else $error("pin driven with no source selected");
    a_hdlc_self_clear: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        s_q.hdlc_req |=> !s_q.hdlc_req || wr_en)
        else $error("block reset bit stuck");
    a_wov_with_expiry: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        $rose(s_q.wd_exp) |-> s_q.wd_overflow_flag)
        else $error("overflow flag missing on expiry");
    // init counter walks from twelve down to zero after release
    a_init_twelve: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        $rose(RST_N_IN) |-> s_q.init_cnt == 4'(`RWG_POR_INIT_CLKS)
        ##11 s_q.init_cnt == 4'h1 ##1 !CHIP_INIT_OUT)
        else $error("init cycle not twelve clocks");
    a_l1_min_width: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        $rose(L1_RESET_OUT) |-> L1_RESET_OUT [*8])
        else $error("layer-1 reset too short");
    a_usb_hw_free: assert property (@(posedge CLK_IN)
        !RST_N_IN |=> !USB_RESET_OUT)
        else $error("hardware reset touched usb");
    // layer-1 held in reset during hardware reset
    a_l1_in_hw_reset: assert property (@(posedge CLK_IN)
        !RST_N_IN |-> L1_RESET_OUT)
        else $error("layer-1 not held in hardware reset");
    a_strobe_passes: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        (s_q.mode[1:0] == 2'b01 && !s_q.rsto_req) |-> RESET_OUT_STROBE_N_OUT == STROBE_IN)
        else $error("strobe not passed to pin");
    // cover points for the main scenarios
    c_wd_pulse: cover property (@(posedge CLK_IN) $rose(WD_RESET_OUT));
    c_awake: cover property (@(posedge CLK_IN) awake_fall && src == RWG_SRC_CI_AWAKE);
    c_src_pulse: cover property (@(posedge CLK_IN) $rose(s_q.src_act));
    c_restart: cover property (@(posedge CLK_IN) wd_start && s_q.wd_lock);
    c_endpoint_init_flag: cover property (@(posedge CLK_IN) $rose(s_q.endpoint_init_flag));
endmodule

// File: testbench/rwg_pin_partner.sv
// far-side device model that watches the reset/strobe pin
`timescale 1ns/100ps
module rwg_pin_partner (
    input wire logic clk_in, // system clock
    input wire logic pin_n_in, // reset pin, low active
    output int pulses_out, // low pulses seen so far
    output int len_out // length of the last low pulse in clocks
);
    int run; // clocks low in the current pulse
    initial begin
        pulses_out = 0;
        len_out = 0;
        run = 0;
    end
    // an external device is held in reset while the pin is low
    always @(posedge clk_in) begin
        if (pin_n_in === 1'b0) begin
            run = run + 1;
        end else if (run != 0) begin
            pulses_out = pulses_out + 1;
            len_out = run;
            run = 0;
        end
    end
endmodule

// File: testbench/rwg_top_tb.sv
// self-checking bench for the reset and watchdog generator
`timescale 1ns/100ps
`include "rwg_params.svh"
module rwg_top_tb;
    import rwg_pkg::*;
    localparam int P = 20; // clocks between frame ticks
    logic CLK_IN = 1'b0;
    logic RST_N_IN = 1'b0;
    logic PSEL_IN = 1'b0, PENABLE_IN = 1'b0, PWRITE_IN = 1'b0;
    logic [11:0] PADDR_IN = 12'h000;
    logic [31:0] PWDATA_IN = 32'h0;
    rwg_word_t PRDATA_OUT;
    logic PREADY_OUT, PSLVERR_OUT, RESET_OUT_STROBE_N_OUT, CHIP_INIT_OUT;
    logic FSC_TICK_IN = 1'b0, SUB_AWAKE_N_IN = 1'b1, CLK_RUN_IN = 1'b1;
    logic USB_BUS_RESET_IN = 1'b0, USB_RST_DONE_IN = 1'b0, STROBE_IN = 1'b0;
    logic [3:0] CI_DOWN_IN = 4'h0;
    logic USB_RESET_OUT, CPU_RESET_OUT, L1_RESET_OUT, HDLC_RESET_OUT;
    logic OSC_WAKE_OUT, WD_RESET_OUT;
    logic wd_seen = 1'b0; // watchdog pulse observed
    int err_total = 0, comparisons = 0, pulses, plen, p0;
    logic [31:0] rd; // last read data
    rwg_top #(.WD_FRAMES(8), .CI_WIDTH(4)) rwg_top_i (
        .CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .PSEL_IN(PSEL_IN),
        .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
        .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
        .PSLVERR_OUT(PSLVERR_OUT), .FSC_TICK_IN(FSC_TICK_IN), .CI_DOWN_IN(CI_DOWN_IN),
        .SUB_AWAKE_N_IN(SUB_AWAKE_N_IN), .USB_BUS_RESET_IN(USB_BUS_RESET_IN),
        .USB_RST_DONE_IN(USB_RST_DONE_IN), .CLK_RUN_IN(CLK_RUN_IN), .STROBE_IN(STROBE_IN),
        .RESET_OUT_STROBE_N_OUT(RESET_OUT_STROBE_N_OUT), .CHIP_INIT_OUT(CHIP_INIT_OUT),
        .USB_RESET_OUT(USB_RESET_OUT), .CPU_RESET_OUT(CPU_RESET_OUT),
        .L1_RESET_OUT(L1_RESET_OUT), .HDLC_RESET_OUT(HDLC_RESET_OUT),
        .OSC_WAKE_OUT(OSC_WAKE_OUT), .WD_RESET_OUT(WD_RESET_OUT));
    rwg_pin_partner rwg_pin_partner_i (.clk_in(CLK_IN), .pin_n_in(RESET_OUT_STROBE_N_OUT),
        .pulses_out(pulses), .len_out(plen));
    // 100 MHz clock
    always #5 CLK_IN = ~CLK_IN;
    // note any watchdog pulse
    always @(posedge CLK_IN) if (WD_RESET_OUT === 1'b1) wd_seen <= 1'b1;
    // compare and count
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // verdict and end of run
    task automatic close_out();
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // one apb transfer, waits for pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge CLK_IN);
        PSEL_IN <= 1'b1;
        PWRITE_IN <= wr;
        PADDR_IN <= a;
        PWDATA_IN <= d;
        @(posedge CLK_IN);
        PENABLE_IN <= 1'b1;
        do begin
            @(posedge CLK_IN);
        end while (PREADY_OUT !== 1'b1);
        rd = PRDATA_OUT;
        chk("pslverr", {31'h0, PSLVERR_OUT}, {31'h0, a > `RWG_ADDR_STAT});
        PSEL_IN <= 1'b0;
        PENABLE_IN <= 1'b0;
        #1;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] m,
        input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, rd & m, e);
    endtask
    // n frame ticks, one every P clocks
    task automatic ticks(input int n);
        repeat (n) begin
            repeat (P - 1) @(posedge CLK_IN);
            FSC_TICK_IN <= 1'b1;
            @(posedge CLK_IN);
            FSC_TICK_IN <= 1'b0;
        end
        @(posedge CLK_IN);
        #1;
    endtask
    // pin pulse count and length against the frame window
    task automatic chk_pulse(input int cnt);
        chk("pin pulses", pulses, cnt);
        chk("pin len", (plen >= P && plen <= 2 * P + 1), 1);
    endtask
    // hardware reset of 12 clocks, then count the init cycle
    task automatic hw_reset(input logic first);
        int n;
        n = 0;
        @(posedge CLK_IN);
        RST_N_IN <= 1'b0;
        #1 if (!first) chk("pin in hw rst", RESET_OUT_STROBE_N_OUT, 1'b0);
        repeat (12) @(posedge CLK_IN);
        #1 chk("pin mode none", RESET_OUT_STROBE_N_OUT, 1'b1);
        chk("usb in hw rst", USB_RESET_OUT, 1'b0);
        chk("l1 in hw rst", L1_RESET_OUT, 1'b1);
        RST_N_IN <= 1'b1;
        repeat (20) begin
            if (CHIP_INIT_OUT === 1'b1) n++;
            @(posedge CLK_IN);
            #1;
        end
        chk("init clocks", n, 12);
    endtask
    // usb soft reset, bus reset and cpu reset bit
    task automatic t_usb();
        int n;
        n = 0;
        wr(`RWG_ADDR_USB, 32'h1);
        chk("usb set", USB_RESET_OUT, 1'b1);
        USB_RST_DONE_IN <= 1'b1;
        while (USB_RESET_OUT === 1'b1 && n < 200) begin
            @(posedge CLK_IN);
            #1 n++;
        end
        chk("usb self clear", USB_RESET_OUT, 1'b0);
        rdchk("endpoint init", `RWG_ADDR_USB, 32'h3, 32'h2);
        wr(`RWG_ADDR_USB, 32'h2);
        rdchk("endpoint init clr", `RWG_ADDR_USB, 32'h3, 32'h0);
        USB_RST_DONE_IN <= 1'b0;
        USB_BUS_RESET_IN <= 1'b1;
        repeat (3) @(posedge CLK_IN);
        #1 chk("usb bus reset", USB_RESET_OUT, 1'b1);
        USB_BUS_RESET_IN <= 1'b0;
        USB_RST_DONE_IN <= 1'b1;
        wr(`RWG_ADDR_SYS, 32'h1);
        chk("cpu reset on", CPU_RESET_OUT, 1'b1);
        wr(`RWG_ADDR_SYS, 32'h0);
        chk("cpu reset off", CPU_RESET_OUT, 1'b0);
        rdchk("unmapped", 12'h020, 32'hffffffff, 32'h0);
    endtask
    // block resets: layer-1 and hdlc, then reset-out bit
    task automatic t_block_soft_reset_reg();
        int n, m;
        n = 0;
        m = 0;
        p0 = pulses;
        wr(`RWG_ADDR_BLOCK_SOFT_RESET_REG, 32'h5);
        repeat (300) begin
            if (HDLC_RESET_OUT === 1'b1) m++;
            if (L1_RESET_OUT === 1'b1) n++;
            @(posedge CLK_IN);
            #1;
        end
        chk("hdlc pulse", m, 1);
        chk("l1 width", n >= `RWG_L1_MIN_CLKS, 1);
        chk("l1 self clear", L1_RESET_OUT, 1'b0);
        chk("no pin pulse", pulses, p0);
        rdchk("block_soft_reset_reg reads", `RWG_ADDR_BLOCK_SOFT_RESET_REG, 32'hffffffff, 32'h0);
        wr(`RWG_ADDR_BLOCK_SOFT_RESET_REG, 32'h2);
        ticks(4);
        chk_pulse(p0 + 1);
    endtask
    // c/i change and subscriber awake with select 10
    task automatic t_ci();
        wr(`RWG_ADDR_MODE, 32'h2);
        p0 = pulses;
        CI_DOWN_IN <= 4'h5;
        ticks(4);
        chk_pulse(p0 + 1);
        rdchk("mode restored", `RWG_ADDR_MODE, 32'h3, 32'h0);
        wr(`RWG_ADDR_MODE, 32'h2);
        SUB_AWAKE_N_IN <= 1'b0;
        #1 chk("osc wake", OSC_WAKE_OUT, 1'b1);
        ticks(4);
        SUB_AWAKE_N_IN <= 1'b1;
        chk_pulse(p0 + 2);
        rdchk("level detect", `RWG_ADDR_STAT, 32'h2, 32'h2);
        wr(`RWG_ADDR_STAT, 32'h3);
        rdchk("stat clr", `RWG_ADDR_STAT, 32'h3, 32'h0);
    endtask
    // strobe mode 01
    task automatic t_strobe();
        wr(`RWG_ADDR_MODE, 32'h1);
        STROBE_IN <= 1'b1;
        @(posedge CLK_IN);
        #1 chk("strobe high", RESET_OUT_STROBE_N_OUT, 1'b1);
        STROBE_IN <= 1'b0;
        @(posedge CLK_IN);
        #1 chk("strobe low", RESET_OUT_STROBE_N_OUT, 1'b0);
        STROBE_IN <= 1'b1;
        @(posedge CLK_IN);
        #1 p0 = pulses;
        CI_DOWN_IN <= 4'ha;
        ticks(4);
        chk("no reset in strobe", pulses, p0);
        rdchk("mode restored", `RWG_ADDR_MODE, 32'h3, 32'h0);
        wr(`RWG_ADDR_MODE, 32'h1);
        wr(`RWG_ADDR_BLOCK_SOFT_RESET_REG, 32'h2);
        ticks(4);
        chk_pulse(p0 + 1);
    endtask
    // watchdog start, lock, restart order, suspend, expiry
    task automatic t_wd();
        wr(`RWG_ADDR_MODE, 32'h3);
        rdchk("wd cleared", `RWG_ADDR_WDOG, 32'hffffffff, 32'h0);
        ticks(3);
        rdchk("wd counts", `RWG_ADDR_WDOG, 32'hffffffff, 32'h3);
        wr(`RWG_ADDR_WDOG, 32'h2);
        wr(`RWG_ADDR_WDOG, 32'h1);
        rdchk("wrong order", `RWG_ADDR_WDOG, 32'hffffffff, 32'h3);
        CLK_RUN_IN <= 1'b0;
        ticks(4);
        CLK_RUN_IN <= 1'b1;
        rdchk("wd suspended", `RWG_ADDR_WDOG, 32'hffffffff, 32'h3);
        wr(`RWG_ADDR_WDOG, 32'h1);
        wr(`RWG_ADDR_WDOG, 32'h2);
        rdchk("wd restarted", `RWG_ADDR_WDOG, 32'hffffffff, 32'h0);
        wr(`RWG_ADDR_MODE, 32'h0);
        rdchk("wd locked", `RWG_ADDR_MODE, 32'h3, 32'h3);
        ticks(9);
        rdchk("wd overflow", `RWG_ADDR_STAT, 32'h1, 32'h1);
        p0 = pulses;
        ticks(12);
        chk("wd pulse", wd_seen, 1'b1);
        chk("wd pin pulse", pulses, p0 + 1);
    endtask
    // hang guard
    initial begin
        #200000;
        err_total++;
        close_out();
    end
    // main sequence
    initial begin
        hw_reset(1'b1);
        wr(`RWG_ADDR_MODE, 32'h2);
        hw_reset(1'b0);
        t_usb();
        t_block_soft_reset_reg();
        t_ci();
        t_strobe();
        t_wd();
        close_out();
    end
endmodule
